// File: flash_cmd_handler.sv
// status, identification and security command handler of the serial flash
`timescale 1ns/100ps
module flash_cmd_handler
    import flash_cmd_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = WRITE_TIME_US * 1000 / CLK_PERIOD_NS
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic spiClk,
    input wire logic csN,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOe,
    // array data for quad and security reads, link clock domain
    input wire logic [7:0] readData,
    // state toward the rest of the device
    output logic [7:0] statusRegisterLow,
    output logic [7:0] statusRegisterHigh,
    output logic [2:0] wrapLengthBits,
    output logic opStart,
    output logic [7:0] opCode,
    output logic [23:0] opAddr
);

    typedef struct packed {
        logic [2:0] csSync;
        sys_state_t state;
        logic [23:0] busyCnt;
        logic nvWrite;
        logic writeEnableLatch;
        logic volArm;
        logic loaded;
        logic [15:0] vol;
        logic [15:0] nv;
        logic [15:0] pend;
        logic opStart;
        logic [7:0] opCode;
        logic [23:0] opAddr;
    } sys_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [15:0] dataIn;
        logic [2:0] wrap;
        logic [15:0] srMeta;
        logic [15:0] srSync;
    } link_t;

    sys_t sys;
    sys_t next_sys;
    link_t link;
    link_t next_link;
    logic fresh;
    logic outClr;
    logic [3:0] outBits;
    logic [3:0] outEn;
    logic csRise;
    logic busyNow;

    // merge of requested status bits into an old value
    function automatic logic [15:0] status_merge(
        input logic [15:0] old,
        input logic [15:0] req,
        input logic shortFrame,
        input logic volatileWrite
    );
        logic [15:0] val;
        val = (old & ~WRITABLE_MASK) | (req & WRITABLE_MASK);
        if (shortFrame) begin
            val = val & ~SHORT_CLEAR_MASK;
        end
        if (volatileWrite) begin
            val = val | (old & VOLATILE_STICKY_MASK);
        end else begin
            val = val | (old & LOCK_MASK);
        end
        return val;
    endfunction

    // identification byte of a maker/device pair
    function automatic logic [7:0] id_byte(input logic second);
        return second ? DEVICE_ID : MAKER_ID;
    endfunction

    // dummy clocks between mode bits and data of quad reads
    function automatic logic [6:0] quad_dummy(input logic [7:0] op);
        case (op)
            OP_QUAD_FAST_READ: quad_dummy = DUMMY_QUAD_FAST;
            OP_QUAD_WORD_READ: quad_dummy = DUMMY_QUAD_WORD;
            OP_MAKER_ID_QUAD: quad_dummy = DUMMY_QUAD_ID;
            default: quad_dummy = DUMMY_NONE;
        endcase
    endfunction

    // program and sector/block erase commands that start a self-timed array cycle
    function automatic logic is_array_op(input logic [7:0] op);
        case (op)
            OP_PAGE_PROGRAM, OP_QUAD_PROGRAM, OP_ERASE_SECTOR,
            OP_ERASE_BLOCK_S, OP_ERASE_BLOCK_L: is_array_op = 1'b1;
            default: is_array_op = 1'b0;
        endcase
    endfunction

    // ---------------- system clock domain ----------------
    assign csRise = sys.csSync[1] & ~sys.csSync[2];
    assign busyNow = sys.state[1];

    always_comb begin
        logic byteEnd;
        logic secOk;
        logic [15:0] req;
        logic shortFrame;
        byteEnd = (link.cnt[2:0] == 3'h0);
        secOk = (link.addr[23:16] == 8'h00)
            && (link.addr[15:8] == SEC_PAGE_1
            || link.addr[15:8] == SEC_PAGE_2
            || link.addr[15:8] == SEC_PAGE_3);
        shortFrame = (link.cnt == CNT_ONE_DATA);
        req = shortFrame ? {sys.vol[15:8], link.dataIn[7:0]}
            : {link.dataIn[7:0], link.dataIn[15:8]};
        next_sys = sys;
        next_sys.csSync = {sys.csSync[1:0], csN};
        next_sys.opStart = 1'b0;
        if (!sys.loaded) begin
            next_sys.vol = sys.nv;
            next_sys.loaded = 1'b1;
        end
        case (sys.state)
            ST_IDLE: begin
                if (csRise) begin
                    next_sys.volArm = 1'b0;
                    case (link.opcode)
                        OP_WRITE_ENABLE: begin
                            if (link.cnt == CNT_OPCODE) begin
                                next_sys.writeEnableLatch = 1'b1;
                            end
                        end
                        OP_VOLATILE_ENABLE: begin
                            if (link.cnt == CNT_OPCODE) begin
                                next_sys.volArm = 1'b1;
                            end
                        end
                        OP_WRITE_DISABLE: begin
                            if (link.cnt == CNT_OPCODE) begin
                                next_sys.writeEnableLatch = 1'b0;
                            end
                        end
                        OP_STATUS_WRITE: begin
                            if (shortFrame || link.cnt == CNT_TWO_DATA) begin
                                if (sys.volArm) begin
                                    next_sys.vol = status_merge(sys.vol, req,
                                        shortFrame, 1'b1);
                                end else if (sys.writeEnableLatch) begin
                                    next_sys.pend = status_merge(sys.nv, req,
                                        shortFrame, 1'b0);
                                    next_sys.nvWrite = 1'b1;
                                    next_sys.state = ST_BUSY;
                                    next_sys.busyCnt = 24'h000000;
                                end
                            end
                        end
                        OP_SEC_ERASE, OP_SEC_PROGRAM: begin
                            if (sys.writeEnableLatch && byteEnd && secOk
                                && link.cnt >= CNT_ADDRESS) begin
                                next_sys.state = ST_BUSY;
                                next_sys.busyCnt = 24'h000000;
                                next_sys.opStart = 1'b1;
                                next_sys.opCode = link.opcode;
                                next_sys.opAddr = link.addr;
                            end
                        end
                        OP_ERASE_CHIP_A, OP_ERASE_CHIP_B: begin
                            if (sys.writeEnableLatch
                                && link.cnt == CNT_OPCODE) begin
                                next_sys.state = ST_BUSY;
                                next_sys.busyCnt = 24'h000000;
                                next_sys.opStart = 1'b1;
                                next_sys.opCode = link.opcode;
                                next_sys.opAddr = 24'h000000;
                            end
                        end
                        default: begin
                            if (is_array_op(link.opcode) && byteEnd
                                && sys.writeEnableLatch
                                && link.cnt >= CNT_ADDRESS) begin
                                next_sys.state = ST_BUSY;
                                next_sys.busyCnt = 24'h000000;
                                next_sys.opStart = 1'b1;
                                next_sys.opCode = link.opcode;
                                next_sys.opAddr = link.addr;
                            end
                        end
                    endcase
                end
            end
            ST_BUSY: begin
                // frames during the cycle are dropped here
                next_sys.busyCnt = sys.busyCnt + 24'h000001;
                if (sys.busyCnt == 24'(BUSY_CYCLES - 1)) begin
                    next_sys.state = ST_IDLE;
                    next_sys.writeEnableLatch = 1'b0;
                    next_sys.nvWrite = 1'b0;
                    if (sys.nvWrite) begin
                        next_sys.nv = sys.pend;
                        next_sys.vol = sys.pend;
                    end
                end
            end
            default: begin
                next_sys.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys <= '{csSync: 3'h7, state: ST_IDLE, busyCnt: 24'h000000,
                nvWrite: 1'b0, writeEnableLatch: 1'b0, volArm: 1'b0,
                loaded: 1'b0, vol: STATUS_RESET, nv: STATUS_RESET,
                pend: STATUS_RESET, opStart: 1'b0, opCode: 8'h00,
                opAddr: 24'h000000};
        end else begin
            sys <= next_sys;
        end
    end

    assign statusRegisterLow = {sys.vol[7:2], sys.writeEnableLatch,
        busyNow};
    assign statusRegisterHigh = sys.vol[15:8];
    assign opStart = sys.opStart;
    assign opCode = sys.opCode;
    assign opAddr = sys.opAddr;

    // ---------------- link clock domain ----------------
    always_ff @(posedge spiClk or posedge csN) begin
        if (csN) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    always_comb begin
        logic [6:0] c;
        c = fresh ? 7'h00 : link.cnt;
        next_link = link;
        next_link.srMeta = {sys.vol[15:8], sys.vol[7:2],
            sys.writeEnableLatch, busyNow};
        next_link.srSync = link.srMeta;
        next_link.cnt = (c == CNT_LAST) ? CNT_REWIND : c + 7'h01;
        if (c < CNT_OPCODE) begin
            next_link.opcode = {fresh ? 7'h00 : link.opcode[6:0], ioIn[0]};
        end else begin
            case (link.opcode)
                OP_MAKER_ID_DUAL: begin
                    if (c < CNT_DUAL_ADDR_END) begin
                        next_link.addr = {link.addr[21:0], ioIn[1:0]};
                    end
                end
                OP_MAKER_ID_QUAD, OP_QUAD_FAST_READ, OP_QUAD_WORD_READ,
                OP_QUAD_OCTAL_READ: begin
                    if (c < CNT_QUAD_ADDR_END) begin
                        next_link.addr = {link.addr[19:0], ioIn};
                    end
                end
                OP_BURST_WRAP: begin
                    if (c == CNT_WRAP_CLOCK && link.srSync[BIT_QE]) begin
                        next_link.wrap = ioIn[2:0];
                    end
                end
                default: begin
                    if (c < CNT_ADDRESS) begin
                        next_link.addr = {link.addr[22:0], ioIn[0]};
                    end
                    if (c < CNT_TWO_DATA) begin
                        next_link.dataIn = {link.dataIn[14:0], ioIn[0]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge spiClk or negedge rst_n) begin
        if (!rst_n) begin
            link <= '{cnt: 7'h00, opcode: 8'h00, addr: 24'h000000,
                dataIn: 16'h0000, wrap: 3'h0, srMeta: STATUS_RESET,
                srSync: STATUS_RESET};
        end else begin
            link <= next_link;
        end
    end

    assign wrapLengthBits = link.wrap;

    // output lanes chosen after each rising edge
    always_comb begin
        logic [6:0] k;
        logic [6:0] start;
        logic [7:0] b;
        logic statusOp;
        outBits = 4'h0;
        outEn = 4'h0;
        k = 7'h00;
        b = 8'h00;
        start = CNT_QUAD_MODE_END + quad_dummy(link.opcode);
        statusOp = (link.opcode == OP_STATUS_LOW)
            || (link.opcode == OP_STATUS_HIGH);
        case (link.opcode)
            OP_STATUS_LOW: if (link.cnt >= CNT_OPCODE) begin
                outBits[1] = link.srSync[~link.cnt[2:0]];
                outEn = 4'h2;
            end
            OP_STATUS_HIGH: if (link.cnt >= CNT_OPCODE) begin
                outBits[1] = link.srSync[{1'b1, ~link.cnt[2:0]}];
                outEn = 4'h2;
            end
            OP_DEVICE_ID: if (link.cnt >= CNT_ADDRESS) begin
                outBits[1] = DEVICE_ID[~link.cnt[2:0]];
                outEn = 4'h2;
            end
            OP_MAKER_ID: if (link.cnt >= CNT_ADDRESS) begin
                b = id_byte(link.cnt[3]);
                outBits[1] = b[~link.cnt[2:0]];
                outEn = 4'h2;
            end
            OP_SEC_READ: if (link.cnt >= CNT_ADDR_DUMMY) begin
                outBits[1] = readData[~link.cnt[2:0]];
                outEn = 4'h2;
            end
            OP_MAKER_ID_DUAL: if (link.cnt >= CNT_DUAL_DATA) begin
                k = link.cnt - CNT_DUAL_DATA;
                b = id_byte(k[2]);
                outBits[1] = b[{~k[1:0], 1'b1}];
                outBits[0] = b[{~k[1:0], 1'b0}];
                outEn = 4'h3;
            end
            OP_MAKER_ID_QUAD, OP_QUAD_FAST_READ, OP_QUAD_WORD_READ,
            OP_QUAD_OCTAL_READ: begin
                if (link.cnt >= start && link.srSync[BIT_QE]) begin
                    k = link.cnt - start;
                    b = (link.opcode == OP_MAKER_ID_QUAD)
                        ? id_byte(k[1]) : readData;
                    outBits = k[0] ? b[3:0] : b[7:4];
                    outEn = 4'hf;
                end
            end
            default: begin
                outEn = 4'h0;
            end
        endcase
        if (link.srSync[BIT_BUSY] && !statusOp) begin
            outEn = 4'h0;
        end
    end

    assign outClr = csN | ~rst_n;

    always_ff @(negedge spiClk or posedge outClr) begin
        if (outClr) begin
            ioOut <= 4'h0;
            ioOe <= 4'h0;
        end else begin
            ioOut <= outBits;
            ioOe <= outEn;
        end
    end

    // ---------------- checks ----------------
    a_wel_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        csRise && !busyNow && link.opcode == OP_WRITE_ENABLE
        && link.cnt == CNT_OPCODE |=> sys.writeEnableLatch)
        else $error("write enable did not set the latch");

    a_wel_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        csRise && !busyNow && link.opcode == OP_WRITE_DISABLE
        && link.cnt == CNT_OPCODE |=> !sys.writeEnableLatch)
        else $error("write disable did not clear the latch");

    a_vol_keeps_wel: assert property (@(posedge sys_clk) disable iff (!rst_n)
        csRise && !busyNow && sys.volArm && link.opcode == OP_STATUS_WRITE
        |=> !busyNow && sys.writeEnableLatch == $past(sys.writeEnableLatch))
        else $error("volatile path changed the latch or started a cycle");

    a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sys.loaded |=> (($past(sys.vol) & LOCK_MASK & ~sys.vol) == 16'h0000))
        else $error("lock bit returned to zero");

    a_nv_needs_wel: assert property (@(posedge sys_clk) disable iff (!rst_n)
        csRise && !busyNow && link.opcode == OP_STATUS_WRITE
        && !sys.writeEnableLatch && !sys.volArm
        |=> !busyNow && $stable(sys.vol))
        else $error("status write ran without the latch");

    a_busy_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busyNow && sys.busyCnt != 24'(BUSY_CYCLES - 1)
        |=> $stable(sys.writeEnableLatch) && $stable(sys.vol))
        else $error("state changed while busy");

    a_end_clears_wel: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(busyNow) |-> !sys.writeEnableLatch && !$past(sys.nvWrite, 2)
        || !sys.writeEnableLatch && sys.vol == sys.nv)
        else $error("write cycle ended with latch set");

    a_arm_consumed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        csRise && !busyNow && link.opcode != OP_VOLATILE_ENABLE
        |=> !sys.volArm ##1 !sys.volArm)
        else $error("volatile qualification survived another instruction");

    a_short_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        csRise && !busyNow && link.opcode == OP_STATUS_WRITE && sys.volArm
        && link.cnt == CNT_ONE_DATA
        |=> !sys.vol[14] && !sys.vol[BIT_QE])
        else $error("short status write kept cleared bits");

    a_status_msb: assert property (@(negedge spiClk) disable iff (outClr)
        link.opcode == OP_STATUS_LOW && link.cnt == CNT_OPCODE
        |=> ioOut[1] == $past(link.srSync[7]) && ioOe == 4'h2)
        else $error("status read did not start with the top bit");

endmodule

// File: flash_cmd_pkg.sv
// shared constants and types for the serial flash command handler
package flash_cmd_pkg;
    // instruction codes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_LOW = 8'h05;
    localparam logic [7:0] OP_STATUS_HIGH = 8'h35;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_DEVICE_ID = 8'hab;
    localparam logic [7:0] OP_MAKER_ID = 8'h90;
    localparam logic [7:0] OP_MAKER_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_MAKER_ID_QUAD = 8'h94;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_QUAD_FAST_READ = 8'heb;
    localparam logic [7:0] OP_QUAD_WORD_READ = 8'he7;
    localparam logic [7:0] OP_QUAD_OCTAL_READ = 8'he3;
    localparam logic [7:0] OP_BURST_WRAP = 8'h77;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
    localparam logic [7:0] OP_ERASE_SECTOR = 8'h20;
    localparam logic [7:0] OP_ERASE_BLOCK_S = 8'h52;
    localparam logic [7:0] OP_ERASE_BLOCK_L = 8'hd8;
    localparam logic [7:0] OP_ERASE_CHIP_A = 8'hc7;
    localparam logic [7:0] OP_ERASE_CHIP_B = 8'h60;
    // status word layout, low byte in bits 7..0
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_PROTECT_MODE_BIT1 = 8;
    localparam int BIT_QE = 9;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] WRITABLE_MASK = 16'h7ffc;
    localparam logic [15:0] LOCK_MASK = 16'h3c00;
    localparam logic [15:0] VOLATILE_STICKY_MASK = 16'h3d00;
    localparam logic [15:0] SHORT_CLEAR_MASK = 16'h4300;
    // security register pages
    localparam logic [7:0] SEC_PAGE_1 = 8'h10;
    localparam logic [7:0] SEC_PAGE_2 = 8'h20;
    localparam logic [7:0] SEC_PAGE_3 = 8'h30;
    // identification bytes, values arbitrary
    localparam logic [7:0] MAKER_ID = 8'h5a;
    localparam logic [7:0] DEVICE_ID = 8'h3c;
    // frame positions in link clocks
    localparam logic [6:0] CNT_OPCODE = 7'h08;
    localparam logic [6:0] CNT_ONE_DATA = 7'h10;
    localparam logic [6:0] CNT_TWO_DATA = 7'h18;
    localparam logic [6:0] CNT_ADDRESS = 7'h20;
    localparam logic [6:0] CNT_ADDR_DUMMY = 7'h28;
    localparam logic [6:0] CNT_DUAL_ADDR_END = 7'h14;
    localparam logic [6:0] CNT_DUAL_DATA = 7'h18;
    localparam logic [6:0] CNT_QUAD_ADDR_END = 7'h0e;
    localparam logic [6:0] CNT_QUAD_MODE_END = 7'h10;
    localparam logic [6:0] CNT_WRAP_CLOCK = 7'h0e;
    localparam logic [6:0] CNT_LAST = 7'h7f;
    localparam logic [6:0] CNT_REWIND = 7'h40;
    localparam logic [6:0] DUMMY_QUAD_FAST = 7'h04;
    localparam logic [6:0] DUMMY_QUAD_WORD = 7'h02;
    localparam logic [6:0] DUMMY_QUAD_ID = 7'h04;
    localparam logic [6:0] DUMMY_NONE = 7'h00;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_TIME_US = 10000;
    // internal write cycle state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } sys_state_t;
endpackage

// File: host_spi_model.sv
// host side controller model driving the link pins in mode 0
`timescale 1ns/100ps
module host_spi_model (
    // link pins
    output logic spiClk,
    output logic csN,
    output logic [3:0] ioIn,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOe
);
    logic hostOe = 1'b0;
    logic hostBit = 1'b1;
    initial begin
        spiClk = 1'b0;
        csN = 1'b1;
    end
    // released lines float high through pull-ups
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ioIn[i] = ioOe[i] ? ioOut[i] : 1'b1;
        end
        if (hostOe) begin
            ioIn[0] = hostBit;
        end
    end
    // opcode, nOut bits sent, then nIn bits read on line 1
    task automatic frame(input logic [7:0] op, input int nOut,
            input logic [31:0] out, input int nIn, output logic [15:0] din);
        logic [39:0] sh;
        sh = {op, out << (32 - nOut)};
        din = '0;
        #13 csN = 1'b0;
        for (int i = 0; i < 8 + nOut + nIn; i++) begin
            hostOe = (i < 8 + nOut);
            hostBit = sh[39];
            #40 spiClk = 1'b1;
            din = {din[14:0], ioIn[1]};
            sh = sh << 1;
            #40 spiClk = 1'b0;
        end
        hostOe = 1'b0;
        #40 csN = 1'b1;
        #400;
    endtask
endmodule

// File: tb_top.sv
// self-checking bench for the serial flash command handler
`timescale 1ns/100ps
module tb_top;
    import flash_cmd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic spiClk, csN, opStart;
    logic [3:0] ioIn, ioOut, ioOe;
    logic [7:0] sLow, sHigh, opCode;
    logic [2:0] wrapLengthBits;
    logic [23:0] opAddr;
    logic [15:0] rd;
    int fail_count = 0;
    int total_checks = 0;
    always #20 sys_clk = ~sys_clk;
    flash_cmd_handler #(.BUSY_CYCLES(20)) flash_cmd_handler_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .spiClk(spiClk), .csN(csN),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .readData(8'ha5),
        .statusRegisterLow(sLow), .statusRegisterHigh(sHigh),
        .wrapLengthBits(wrapLengthBits), .opStart(opStart),
        .opCode(opCode), .opAddr(opAddr));
    host_spi_model host_spi_model_i (.spiClk(spiClk), .csN(csN),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic op(input logic [7:0] c, input int n, input logic [31:0] d,
            input int nIn);
        host_spi_model_i.frame(c, n, d, nIn, rd);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 200 && sLow[0] !== 1'b0; i++) begin
            @(posedge sys_clk);
        end
    endtask
    task automatic test_latch;
        chk({sHigh, sLow}, 16'h0000);
        op(OP_WRITE_ENABLE, 0, 0, 0);
        op(OP_STATUS_LOW, 0, 0, 16);
        chk(rd, 16'h0202);
        op(OP_WRITE_DISABLE, 0, 0, 0);
        chk({sHigh, sLow}, 16'h0000);
    endtask
    task automatic test_volatile;
        op(OP_VOLATILE_ENABLE, 0, 0, 0);
        op(OP_STATUS_WRITE, 16, 32'hfc41, 0);
        chk({sHigh, sLow}, 16'h41fc);
        op(OP_VOLATILE_ENABLE, 0, 0, 0);
        op(OP_STATUS_WRITE, 8, 32'h00, 0);
        chk({sHigh, sLow}, 16'h0100);
        op(OP_STATUS_WRITE, 16, 32'hfc41, 0);
        chk({sHigh, sLow}, 16'h0100);
    endtask
    task automatic test_nonvolatile;
        op(OP_WRITE_ENABLE, 0, 0, 0);
        op(OP_STATUS_WRITE, 16, 32'h1c00, 0);
        chk({8'h00, sLow}, 16'h0003);
        wait_idle();
        chk({8'h00, sLow}, 16'h001c);
    endtask
    task automatic test_ident;
        op(OP_DEVICE_ID, 24, 0, 16);
        chk(rd, {DEVICE_ID, DEVICE_ID});
        op(OP_WRITE_ENABLE, 0, 0, 0);
        op(OP_SEC_ERASE, 24, 32'h001000, 0);
        wait_idle();
        chk({opCode, opAddr[15:8]}, 16'h4410);
        chk({8'h00, sLow}, 16'h001c);
        op(OP_WRITE_ENABLE, 0, 0, 0);
        op(OP_SEC_ERASE, 24, 32'h000000, 0);
        chk({opAddr[15:8], sLow}, 16'h101e);
    endtask
    initial begin
        #1000000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        test_latch();
        test_volatile();
        test_nonvolatile();
        test_ident();
        test_done();
    end
endmodule
